/* File: prc_defines.svh */
// Constants for the preset counter run logic.
// Overview of operation
// - Protect level gates mode, display, reset, up/down keys.
// - Mode+reset 1 s, mode 3 s change mode.
// - Up/down keys adjust each set value digit; down key works in four-digit mode only.
// - Present value reaching set value drives outputs.
// - Batch count increments on each count completion.
// - Batch count reaching batch set value sets first output.
// - Dual value is sum or difference of inputs.
// - Dual value reaching dual set value drives outputs in hold mode; one-shot starts on the next count made at that value.
// - Dual mode: both inputs count upward.
// - Counting starts after first input turns on.
// - One-stage model acts as second output only.
// - Some configs switch both outputs together.
// - Four-digit full scale is 9999.
// - Wraparound modes return present value to zero.
// - Counts ignored while first reset asserted, except input b in dual mode.
// - First reset ends an active one-shot.
// - Outputs on at power loss return on recovery.
// - Dual: first reset zeroes first input only.
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH
`define PRC_CLK_NS      10
`define PRC_MS_NS       1000000
`define PRC_MS_CYC      (`PRC_MS_NS / `PRC_CLK_NS)
`define PRC_CFGSEL_MS   1000
`define PRC_FUNCSET_MS  3000
`define PRC_W30_NS      16700000
`define PRC_W30_CYC     (`PRC_W30_NS / `PRC_CLK_NS)
`define PRC_W5K_NS      100000
`define PRC_W5K_CYC     (`PRC_W5K_NS / `PRC_CLK_NS)
`define PRC_FS6         20'h0_F423F
`define PRC_FS4         20'h0_270F
`define PRC_SV_RST      20'h0_0000
`define PRC_SV_MAIN     2'h1
`define PRC_SV_BATCH    2'h2
`define PRC_SV_DUAL     2'h3
`endif

/* File: prc_pkg.sv */
// Types shared by the preset counter run logic.
package prc_pkg;
  typedef enum logic [2:0] {CFG_ONE, CFG_TWO, CFG_TOTAL, CFG_BATCH, CFG_DUAL} prc_cfg_t;
  typedef enum logic {OM_HOLD, OM_ONESHOT} prc_omode_t;
  typedef enum logic [1:0] {HOLD_IDLE, HOLD_COMBO, HOLD_ALONE, HOLD_DONE} prc_hold_t;
endpackage

/* File: prc_pulse_qual.sv */
// Count input pulse width qualifier.
`timescale 1ns/1ps
module prc_pulse_qual #(
  parameter int SLOW_CYC = 1670000,
  parameter int FAST_CYC = 10000
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic sig,
  input  wire logic fast,
  output logic      count_pulse_r
);
  logic [20:0] cnt_r;
  logic [20:0] thr;

  assign thr = fast ? FAST_CYC[20:0] : SLOW_CYC[20:0];

  // Shorter highs are treated as noise and never reach the counter.
  always_ff @(posedge ref_clk) begin
    if (srst || !sig) begin
      cnt_r <= 21'h00_0000;
    end else if (cnt_r != thr) begin
      cnt_r <= cnt_r + 21'h00_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_pulse_r <= 1'b0;
    end else begin
      count_pulse_r <= sig && (cnt_r == thr - 21'h00_0001);
    end
  end
endmodule

/* File: prc_run_logic.sv */
// Run-mode logic of the multifunction preset counter.
`timescale 1ns/1ps
`include "prc_defines.svh"
module prc_run_logic #(
  parameter int MS_CYC  = `PRC_MS_CYC,
  parameter int W30_CYC = `PRC_W30_CYC,
  parameter int W5K_CYC = `PRC_W5K_CYC
) (
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire logic               count_input_a,
  input  wire logic               count_input_b,
  input  wire logic               speed_fast,
  input  wire logic               first_reset_in,
  input  wire logic               second_reset_in,
  input  wire logic               key_mode,
  input  wire logic               first_reset_key,
  input  wire logic               key_up,
  input  wire logic               key_down,
  input  wire logic               key_disp,
  input  wire logic               key_protect_on,
  input  wire logic [2:0]         lock_level,
  input  wire logic [1:0]         edit_sel,
  input  wire logic [2:0]         edit_digit,
  input  wire prc_pkg::prc_cfg_t  cfg_sel,
  input  wire prc_pkg::prc_omode_t out_mode,
  input  wire logic               six_digit,
  input  wire logic               two_stage_model,
  input  wire logic               dual_add,
  input  wire logic [13:0]        oneshot_ms,
  input  wire logic               nv_restore,
  input  wire logic [3:0]         nv_state_in,
  output logic                    first_output,
  output logic                    second_output,
  output logic                    cfg_select_req,
  output logic                    func_set_req,
  output logic                    disp_sel_r,
  output logic [19:0]             pv_a_r,
  output logic [19:0]             pv_b_r,
  output logic [19:0]             total_r,
  output logic [19:0]             batch_r,
  output logic signed [20:0]      dual_val,
  output logic                    nv_wr_r,
  output logic [3:0]              nv_state_r
);
  import prc_pkg::*;

  logic [19:0]        fs;
  logic [19:0]        sv_r [4];
  logic               ev_a;
  logic               ev_b;
  logic               armed_r;
  logic               is_dual;
  logic               mode_ok;
  logic               disp_ok;
  logic               reset_ok;
  logic               updn_ok;
  logic [4:0]         key_q_r;
  logic               rkey_evt;
  logic               rst1;
  logic               rst2;
  logic               ms_tick;
  logic [16:0]        ms_div_r;
  prc_hold_t          hold_r;
  logic [11:0]        hold_ms_r;
  logic               cnt_a;
  logic               cnt_b;
  logic [19:0]        pv_inc;
  logic               hit;
  logic               out_hold_r;
  logic               first_output_hold_r;
  logic               batch_out_r;
  logic               os_active_r;
  logic [13:0]        os_ms_r;
  logic               main_on;
  logic [3:0]         nv_nxt;
  logic signed [20:0] dsv;

  assign fs = six_digit ? `PRC_FS6 : `PRC_FS4;
  assign is_dual = (cfg_sel == CFG_DUAL);

  // Protect level gating of the front-panel keys.
  assign mode_ok  = !key_protect_on;
  assign disp_ok  = !key_protect_on || (lock_level != 3'h5);
  assign reset_ok = !key_protect_on || (lock_level == 3'h1) || (lock_level == 3'h3);
  assign updn_ok  = !key_protect_on || (lock_level == 3'h1) || (lock_level == 3'h2);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      key_q_r <= 5'h00;
    end else begin
      key_q_r <= {key_disp, key_down, key_up, first_reset_key, key_mode};
    end
  end

  assign rkey_evt = first_reset_key && !key_q_r[1] && reset_ok && !key_mode;
  assign rst1 = first_reset_in || rkey_evt;
  assign rst2 = second_reset_in;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      disp_sel_r <= 1'b0;
    end else if (key_disp && !key_q_r[4] && disp_ok) begin
      disp_sel_r <= !disp_sel_r;
    end
  end

  // Millisecond enable for key holds and the one-shot timer.
  always_ff @(posedge ref_clk) begin
    if (srst || ms_tick) begin
      ms_div_r <= 17'h0_0000;
    end else begin
      ms_div_r <= ms_div_r + 17'h0_0001;
    end
  end
  assign ms_tick = (ms_div_r == MS_CYC[16:0] - 17'h0_0001);

  // Key hold detection starts one tick below zero, so a partial first millisecond never counts.
  always_ff @(posedge ref_clk) begin
    if (srst || !mode_ok || !key_mode) begin
      hold_r    <= HOLD_IDLE;
      hold_ms_r <= 12'h000;
    end else begin
      unique case (hold_r)
        HOLD_IDLE: begin
          hold_r    <= first_reset_key ? HOLD_COMBO : HOLD_ALONE;
          hold_ms_r <= 12'hFFF;
        end
        HOLD_COMBO: begin
          if (!first_reset_key) begin
            hold_r    <= HOLD_IDLE;
          end else if (hold_ms_r == 12'(`PRC_CFGSEL_MS)) begin
            hold_r <= HOLD_DONE;
          end else if (ms_tick) begin
            hold_ms_r <= hold_ms_r + 12'h001;
          end
        end
        HOLD_ALONE: begin
          if (first_reset_key) begin
            hold_r <= HOLD_IDLE;
          end else if (hold_ms_r == 12'(`PRC_FUNCSET_MS)) begin
            hold_r <= HOLD_DONE;
          end else if (ms_tick) begin
            hold_ms_r <= hold_ms_r + 12'h001;
          end
        end
        HOLD_DONE: hold_r <= HOLD_DONE;
      endcase
    end
  end
  assign cfg_select_req = mode_ok && key_mode && first_reset_key && (hold_r == HOLD_COMBO)
                          && (hold_ms_r == 12'(`PRC_CFGSEL_MS));
  assign func_set_req = mode_ok && key_mode && !first_reset_key && (hold_r == HOLD_ALONE)
                        && (hold_ms_r == 12'(`PRC_FUNCSET_MS));

  // Set values, one register each, adjusted a decimal digit at a time.
  function automatic logic [19:0] pow10(input logic [2:0] d);
    unique case (d)
      3'h0:    pow10 = 20'h0_0001;
      3'h1:    pow10 = 20'h0_000A;
      3'h2:    pow10 = 20'h0_0064;
      3'h3:    pow10 = 20'h0_03E8;
      3'h4:    pow10 = 20'h0_2710;
      3'h5:    pow10 = 20'h1_86A0;
      default: pow10 = 20'h0_0000;
    endcase
  endfunction

  for (genvar i = 0; i < 4; i++) begin : g_sv
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        sv_r[i] <= `PRC_SV_RST;
      end else if (updn_ok && edit_sel == 2'(i)) begin
        if (key_up && !key_q_r[2]) begin
          sv_r[i] <= (fs - sv_r[i] < pow10(edit_digit)) ? fs : sv_r[i] + pow10(edit_digit);
        end else if (key_down && !key_q_r[3] && !six_digit) begin
          // Six-digit units have no down key, so down presses are dropped there.
          sv_r[i] <= (sv_r[i] < pow10(edit_digit)) ? 20'h0_0000
                     : sv_r[i] - pow10(edit_digit);
        end
      end
    end
  end

  prc_pulse_qual #(.SLOW_CYC(W30_CYC), .FAST_CYC(W5K_CYC)) u_qual_a (
    .ref_clk       (ref_clk),
    .srst          (srst),
    .sig           (count_input_a),
    .fast          (speed_fast),
    .count_pulse_r (ev_a)
  );
  prc_pulse_qual #(.SLOW_CYC(W30_CYC), .FAST_CYC(W5K_CYC)) u_qual_b (
    .ref_clk       (ref_clk),
    .srst          (srst),
    .sig           (count_input_b),
    .fast          (speed_fast),
    .count_pulse_r (ev_b)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      armed_r <= 1'b0;
    end else if (ev_a) begin
      armed_r <= 1'b1;
    end
  end

  // In dual mode input b counts up; otherwise it counts the value down.
  assign cnt_a = ev_a && !first_reset_in;
  assign cnt_b = ev_b && armed_r && (is_dual || !first_reset_in);
  assign pv_inc = (pv_a_r == fs) ? ((out_mode == OM_ONESHOT) ? 20'h0_0000 : fs)
                  : pv_a_r + 20'h0_0001;
  assign hit = is_dual ? (cnt_a || cnt_b) && (dual_val == dsv)
               : cnt_a && !cnt_b && (pv_inc == sv_r[`PRC_SV_MAIN]);

  always_ff @(posedge ref_clk) begin
    if (srst || rst1) begin
      pv_a_r <= 20'h0_0000;
    end else if (is_dual) begin
      if (cnt_a && pv_a_r != fs) begin
        pv_a_r <= pv_a_r + 20'h0_0001;
      end
    end else if (hit && out_mode == OM_ONESHOT) begin
      pv_a_r <= 20'h0_0000;
    end else if (cnt_a && !cnt_b) begin
      pv_a_r <= pv_inc;
    end else if (cnt_b && !cnt_a && pv_a_r != 20'h0_0000) begin
      pv_a_r <= pv_a_r - 20'h0_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || (is_dual && rst2)) begin
      pv_b_r <= 20'h0_0000;
    end else if (is_dual && cnt_b && pv_b_r != fs) begin
      pv_b_r <= pv_b_r + 20'h0_0001;
    end
  end

  assign dsv = $signed({1'b0, sv_r[`PRC_SV_DUAL]});
  // After an event the compare sees the updated values one cycle later.
  assign dual_val = dual_add ? $signed({1'b0, pv_a_r}) + $signed({1'b0, pv_b_r})
                    : $signed({1'b0, pv_a_r}) - $signed({1'b0, pv_b_r});

  always_ff @(posedge ref_clk) begin
    if (srst || rst2) begin
      total_r <= 20'h0_0000;
    end else if (cnt_a) begin
      total_r <= (total_r == fs) ? 20'h0_0000 : total_r + 20'h0_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || rst2 || (rkey_evt && disp_sel_r)) begin
      batch_r <= 20'h0_0000;
    end else if (cfg_sel == CFG_BATCH && hit) begin
      batch_r <= (batch_r == fs) ? 20'h0_0000 : batch_r + 20'h0_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || rst2 || (rkey_evt && disp_sel_r)) begin
      batch_out_r <= 1'b0;
    end else if (nv_restore) begin
      batch_out_r <= nv_state_in[2];
    end else if (cfg_sel == CFG_BATCH && sv_r[`PRC_SV_BATCH] != 20'h0_0000
                 && batch_r >= sv_r[`PRC_SV_BATCH]) begin
      batch_out_r <= 1'b1;
    end
  end

  // Hold outputs stay on until the first reset.
  always_ff @(posedge ref_clk) begin
    if (srst || rst1) begin
      out_hold_r <= 1'b0;
    end else if (nv_restore) begin
      out_hold_r <= nv_state_in[0];
    end else if (armed_r && out_mode == OM_HOLD && (is_dual ? dual_val >= dsv
                 : pv_a_r >= sv_r[`PRC_SV_MAIN])) begin
      out_hold_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || rst1) begin
      first_output_hold_r <= 1'b0;
    end else if (nv_restore) begin
      first_output_hold_r <= nv_state_in[1];
    end else if (armed_r && pv_a_r >= sv_r[0]) begin
      first_output_hold_r <= 1'b1;
    end
  end

  // A recurring completion during a one-shot simply restarts its timer.
  always_ff @(posedge ref_clk) begin
    if (srst || rst1) begin
      os_active_r <= 1'b0;
      os_ms_r     <= 14'h0000;
    end else if ((nv_restore && nv_state_in[3]) || (out_mode == OM_ONESHOT && hit)) begin
      os_active_r <= 1'b1;
      os_ms_r     <= 14'h0000;
    end else if (os_active_r && ms_tick) begin
      os_active_r <= (os_ms_r + 14'h0001 < oneshot_ms);
      os_ms_r     <= os_ms_r + 14'h0001;
    end
  end

  assign main_on = (out_mode == OM_HOLD) ? out_hold_r : os_active_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      first_output  <= 1'b0;
      second_output <= 1'b0;
    end else begin
      second_output <= main_on;
      if (!two_stage_model) begin
        first_output <= 1'b0;
      end else if (cfg_sel == CFG_TWO) begin
        first_output <= first_output_hold_r;
      end else if (cfg_sel == CFG_BATCH) begin
        first_output <= batch_out_r;
      end else begin
        first_output <= main_on;
      end
    end
  end

  // Output state is offered for nonvolatile storage whenever it changes.
  assign nv_nxt = {os_active_r, batch_out_r, first_output_hold_r, out_hold_r};
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      nv_state_r <= 4'h0;
      nv_wr_r    <= 1'b0;
    end else begin
      nv_state_r <= nv_nxt;
      nv_wr_r    <= (nv_nxt != nv_state_r);
    end
  end

  kp_mode_a: assert property (@(posedge ref_clk) disable iff (srst)
    key_protect_on |-> !cfg_select_req && !func_set_req)
    else $error("mode change passed key protect");
  kp_disp_a: assert property (@(posedge ref_clk) disable iff (srst)
    key_protect_on && lock_level == 3'h5 |=> $stable(disp_sel_r))
    else $error("display switched at level five");
  hold_time_a: assert property (@(posedge ref_clk) disable iff (srst)
    func_set_req |-> hold_ms_r == 12'(`PRC_FUNCSET_MS) && $past(key_mode))
    else $error("function mode entered early");
  rst_block_a: assert property (@(posedge ref_clk) disable iff (srst)
    first_reset_in |=> pv_a_r == 20'h0_0000)
    else $error("count moved under reset");
  os_cancel_a: assert property (@(posedge ref_clk) disable iff (srst)
    first_reset_in ##1 1'b1 |-> !os_active_r ##1 !second_output || out_mode == OM_HOLD)
    else $error("one-shot survived reset");
  one_stage_a: assert property (@(posedge ref_clk) disable iff (srst)
    !two_stage_model |=> !first_output)
    else $error("one-stage model drove first output");
  same_out_a: assert property (@(posedge ref_clk) disable iff (srst)
    two_stage_model && (cfg_sel == CFG_ONE || cfg_sel == CFG_TOTAL || cfg_sel == CFG_DUAL)
    |=> first_output == second_output)
    else $error("outputs split in single-set config");
  armed_a: assert property (@(posedge ref_clk) disable iff (srst)
    !armed_r |-> pv_a_r == 20'h0_0000 && total_r == 20'h0_0000)
    else $error("counted before first input");
  fs_a: assert property (@(posedge ref_clk) disable iff (srst)
    pv_a_r <= fs || $changed(six_digit))
    else $error("present value beyond full scale");
endmodule

/* File: prc_src_model.sv */
// Model of the count signal sources that feed the run logic.
`timescale 1ns/1ps
module prc_src_model (
  input  wire logic ref_clk,
  output logic      count_input_a,
  output logic      count_input_b
);
  initial begin
    count_input_a = 1'b0;
    count_input_b = 1'b0;
  end
  // Lines rest low between pulses, as an open contact leaves them.
  // A width below the qualifier minimum is only sent when the bench asks for a refusal.
  task automatic pulse(input logic do_a, input logic do_b, input int width);
    for (int i = 0; i < 2 * width + width / 2; i++) begin
      @(posedge ref_clk);
      #1;
      count_input_a = do_a && (i < width);
      count_input_b = do_b && (i >= width / 2) && (i < width + width / 2);
    end
  endtask
endmodule

/* File: test_preset_counter_run_logic.sv */
// Self-checking bench for the preset counter run logic.
`timescale 1ns/1ps
module test_preset_counter_run_logic;
  import prc_pkg::*;
  localparam int         MS     = 10;
  localparam logic [4:0] K_MODE = 5'h01;
  localparam logic [4:0] K_RST  = 5'h02;
  localparam logic [4:0] K_UP   = 5'h04;
  localparam logic [4:0] K_DISP = 5'h10;
  typedef struct packed {
    logic [2:0] lvl;
    logic       disp_ok;
    logic       rst_ok;
  } prc_row_t;
  prc_row_t rows [5] = '{'{3'h1, 1'h1, 1'h1}, '{3'h2, 1'h1, 1'h0}, '{3'h3, 1'h1, 1'h1},
                         '{3'h4, 1'h1, 1'h0}, '{3'h5, 1'h0, 1'h0}};
  logic               ref_clk = 1'b0;
  logic               srst = 1'b1;
  logic [4:0]         keys = 5'h00;
  logic               speed_fast, first_reset_in, second_reset_in, key_protect_on, six_digit;
  logic               two_stage_model, dual_add, nv_restore, exp_disp;
  logic [2:0]         lock_level, edit_digit;
  logic [1:0]         edit_sel;
  logic [13:0]        oneshot_ms;
  logic [3:0]         nv_state_in, nv_state_r;
  prc_cfg_t           cfg_sel;
  prc_omode_t         out_mode;
  logic               count_input_a, count_input_b, first_output, second_output;
  logic               cfg_select_req, func_set_req, disp_sel_r, nv_wr_r;
  logic [19:0]        pv_a_r, pv_b_r, total_r, batch_r;
  logic signed [20:0] dual_val;
  int                 errors = 0;
  int                 n_tests = 0;
  int                 cnt, n;

  prc_src_model src (.ref_clk(ref_clk), .count_input_a(count_input_a),
    .count_input_b(count_input_b));
  prc_run_logic #(.MS_CYC(MS), .W30_CYC(20), .W5K_CYC(4)) dut (
    .ref_clk(ref_clk), .srst(srst), .count_input_a(count_input_a),
    .count_input_b(count_input_b), .speed_fast(speed_fast), .first_reset_in(first_reset_in),
    .second_reset_in(second_reset_in), .key_mode(keys[0]), .first_reset_key(keys[1]),
    .key_up(keys[2]), .key_down(keys[3]), .key_disp(keys[4]),
    .key_protect_on(key_protect_on), .lock_level(lock_level), .edit_sel(edit_sel),
    .edit_digit(edit_digit), .cfg_sel(cfg_sel), .out_mode(out_mode), .six_digit(six_digit),
    .two_stage_model(two_stage_model), .dual_add(dual_add), .oneshot_ms(oneshot_ms),
    .nv_restore(nv_restore), .nv_state_in(nv_state_in), .first_output(first_output),
    .second_output(second_output), .cfg_select_req(cfg_select_req),
    .func_set_req(func_set_req), .disp_sel_r(disp_sel_r), .pv_a_r(pv_a_r), .pv_b_r(pv_b_r),
    .total_r(total_r), .batch_r(batch_r), .dual_val(dual_val), .nv_wr_r(nv_wr_r),
    .nv_state_r(nv_state_r));

  always #5 ref_clk = ~ref_clk;

  task automatic tick(input int k = 1);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic press(input logic [4:0] m);
    keys = keys | m;
    tick();
    keys = keys & ~m;
    tick(2);
  endtask
  task automatic set_sv(input logic [1:0] sel, input int times);
    edit_sel = sel;
    edit_digit = 3'h0;
    repeat (times) press(K_UP);
  endtask
  task automatic do_reset();
    srst = 1'b1;
    tick(8);
    srst = 1'b0;
    tick();
  endtask
  task automatic pa(input int times);
    repeat (times) src.pulse(1'b1, 1'b0, 6);
  endtask
  // The first millisecond tick comes from a free divider, so the span may run one tick long.
  task automatic hold_keys(input logic [4:0] m, input int lo, input int hi);
    keys = m;
    n = 0;
    while (cfg_select_req !== 1'b1 && func_set_req !== 1'b1 && n <= hi) begin
      tick();
      n++;
    end
    check("hold span", 1'b1, n >= lo && n <= hi);
    check("which request", (m == K_MODE) ? 2'h1 : 2'h2, {cfg_select_req, func_set_req});
    keys = 5'h00;
    tick();
  endtask
  task automatic print_verdict();
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The two key holds take about 40000 cycles; everything else is a few hundred.
  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    print_verdict();
  end

  initial begin
    {speed_fast, six_digit, two_stage_model, dual_add} = 4'hF;
    {first_reset_in, second_reset_in, key_protect_on, nv_restore} = 4'h0;
    {lock_level, edit_sel, edit_digit, nv_state_in} = 12'h400;
    oneshot_ms = 14'h0005;
    cfg_sel = CFG_ONE;
    out_mode = OM_HOLD;
    exp_disp = 1'b0;
    do_reset();
    check("pv_a after reset", 20'h0_0000, pv_a_r);
    check("outputs after reset", 2'h0, {first_output, second_output});
    key_protect_on = 1'b1;
    cnt = 0;
    for (int i = 0; i < 5; i++) begin
      lock_level = rows[i].lvl;
      pa(1);
      cnt++;
      press(K_DISP);
      exp_disp = exp_disp ^ rows[i].disp_ok;
      check("display select", exp_disp, disp_sel_r);
      press(K_RST);
      if (rows[i].rst_ok) begin
        cnt = 0;
      end
      check("pv_a after reset key", cnt, pv_a_r);
    end
    key_protect_on = 1'b0;
    do_reset();
    set_sv(2'h1, 3);
    press(5'h08);
    speed_fast = 1'b0;
    src.pulse(1'b1, 1'b0, 22);
    speed_fast = 1'b1;
    src.pulse(1'b1, 1'b0, 3);
    check("short pulse refused", 20'h0_0001, pv_a_r);
    pa(1);
    check("below set value", 2'h0, {first_output, second_output});
    pa(1);
    check("outputs at set value", 2'h3, {first_output, second_output});
    first_reset_in = 1'b1;
    pa(1);
    check("count blocked in reset", 21'h00_0000, {pv_a_r, first_output});
    first_reset_in = 1'b0;
    out_mode = OM_ONESHOT;
    pa(3);
    check("pv back to zero", 20'h0_0000, pv_a_r);
    check("total count", 20'h0_0006, total_r);
    check("one-shot on", 2'h3, {first_output, second_output});
    first_reset_in = 1'b1;
    tick(2);
    check("one-shot cut by reset", 2'h0, {first_output, second_output});
    first_reset_in = 1'b0;
    do_reset();
    cfg_sel = CFG_BATCH;
    oneshot_ms = 14'h0001;
    set_sv(2'h1, 1);
    set_sv(2'h2, 2);
    pa(1);
    check("batch count one", 20'h0_0001, batch_r);
    check("batch output off", 1'b0, first_output);
    pa(1);
    check("batch count two", 20'h0_0002, batch_r);
    check("batch output on", 1'b1, first_output);
    second_reset_in = 1'b1;
    tick();
    second_reset_in = 1'b0;
    tick();
    check("batch reset two", 21'h00_0000, {batch_r, first_output});
    do_reset();
    cfg_sel = CFG_DUAL;
    out_mode = OM_HOLD;
    set_sv(2'h3, 3);
    src.pulse(1'b0, 1'b1, 6);
    check("b before first a", 20'h0_0000, pv_b_r);
    src.pulse(1'b1, 1'b1, 6);
    check("b counts up", 20'h0_0001, pv_b_r);
    check("no dual hit yet", 2'h0, {first_output, second_output});
    pa(1);
    check("dual sum", 21'h00_0003, dual_val);
    check("dual hit", 2'h3, {first_output, second_output});
    dual_add = 1'b0;
    tick();
    check("dual difference", 21'h00_0001, dual_val);
    first_reset_in = 1'b1;
    src.pulse(1'b1, 1'b1, 6);
    check("a held at zero", 20'h0_0000, pv_a_r);
    check("dual with a in reset", 21'h1F_FFFE, dual_val);
    first_reset_in = 1'b0;
    do_reset();
    cfg_sel = CFG_ONE;
    nv_state_in = 4'h1;
    nv_restore = 1'b1;
    tick();
    nv_restore = 1'b0;
    tick();
    check("stored state", 5'h11, {nv_wr_r, nv_state_r});
    tick(2);
    check("restored outputs", 2'h3, {first_output, second_output});
    hold_keys(K_MODE | K_RST, 1000 * MS, 1002 * MS);
    hold_keys(K_MODE, 3000 * MS, 3002 * MS);
    print_verdict();
  end
endmodule
